// ---- design/aol_pkg.sv ----
/*
 * shared constants, types and the checksum step for the channel output
 * latch link; assumes one system clock on both ends of the link
 */
package aol_pkg;

// ==========================================================================
// word layout and addresses
localparam int CH_N = 3;
localparam int WORD_W = 24;
localparam int CMD_BITS = 8;
localparam logic [4:0] ADDR_CH0 = 5'h00;
localparam logic [4:0] ADDR_CH2 = 5'h02;
localparam logic [4:0] ADDR_STATUS = 5'h09;
localparam logic [15:0] CRC_POLY = 16'h8005;

// ==========================================================================
// timing
localparam int SYS_CLK_NS = 25;
localparam int UPDATE_DELAY_NS = 50;
localparam int UPDATE_DELAY_CYC = (UPDATE_DELAY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

// ==========================================================================
// controller register indices and field positions
localparam logic [3:0] HREG_CTRL = 4'h0;
localparam logic [3:0] HREG_EVENT = 4'h1;
localparam logic [3:0] HREG_MASK = 4'h2;
localparam logic [3:0] HREG_DATA0 = 4'h3;
localparam logic [3:0] HREG_DATA2 = 4'h5;
localparam logic [3:0] HREG_CRC = 4'h6;
localparam int CTRL_GO = 0;
localparam int CTRL_ADDR_LSB = 1;
localparam int CTRL_CRC_EN = 6;
localparam int CTRL_CRC32 = 7;
localparam int CTRL_WAIT_DR = 8;
localparam int CTRL_BUSY = 9;
localparam int EV_DONE = 0;
localparam int EV_CRC_ERR = 1;
localparam int EV_DR = 2;

typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_CMD = 2'b01,
    DS_DATA = 2'b11
} aol_dev_state_e;

typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_WAIT_DR = 3'b001,
    HS_DELAY = 3'b011,
    HS_CMD = 3'b010,
    HS_WORD = 3'b110,
    HS_CRC = 3'b111,
    HS_END = 3'b101
} aol_host_state_e;

// one message bit into the running checksum, msb first
function automatic logic [15:0] aol_crc_step(input logic [15:0] c,
                                             input logic b);
    aol_crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
endfunction

endpackage

// ---- design/aol_link_if.sv ----
/*
 * serial link between converter end and controller end;
 * the data output is released high (pull-up) while its enable is high
 */
`timescale 1ns/1ps
`default_nettype none
interface aol_link_if;
    logic sck;
    logic cs_n;
    logic sdi;
    logic sdo_out;
    logic sdo_oe_n;
    logic sdo;
    logic data_ready_n;

    // ======================================================================
    // wire resolution
    assign sdo = sdo_oe_n ? 1'b1 : sdo_out;

    modport dev (
        input sck,
        input cs_n,
        input sdi,
        output sdo_out,
        output sdo_oe_n,
        output data_ready_n
    );
    modport host (
        output sck,
        output cs_n,
        output sdi,
        input sdo,
        input data_ready_n
    );
endinterface
`default_nettype wire

// ---- design/aol_device.sv ----
/*
 * converter end: two latch stages for the three channel words, ready
 * pulse, continuous read with optional checksum on the serial output.
 * assumes conversion results arrive as one-cycle strobes on sys_clk and
 * that the link pins come from outside the clock domain (mode 0,0).
 */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module aol_device
    import aol_pkg::*;
#(
    parameter int unsigned MOD_DIV = 4
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    aol_link_if.dev link,
    input wire logic [CH_N-1:0] conv_strobe,
    input wire logic [CH_N-1:0][WORD_W-1:0] conv_data,
    input wire logic [CH_N-1:0] channel_active,
    input wire logic link_latch_all,
    input wire logic read_checksum_enable,
    input wire logic checksum_width32,
    output logic [CH_N-1:0] channel_ready_flags
);

    typedef struct packed {
        aol_dev_state_e st;
        logic [2:0] sck_s;
        logic [2:0] cs_s;
        logic [2:0] sdi_s;
        logic sck_f;
        logic cs_f;
        logic sdi_f;
        logic [2:0] cmd_cnt;
        logic [7:0] cmd;
        logic [4:0] ptr;
        logic is_read;
        logic [31:0] sr;
        logic [5:0] left;
        logic seq_end;
        logic in_crc;
        logic [15:0] crc;
        logic [CH_N-1:0][WORD_W-1:0] raw;
        logic [CH_N-1:0][WORD_W-1:0] latch;
        logic [CH_N-1:0] pend;
        logic [CH_N-1:0] flags;
        logic [7:0] mod_cnt;
        logic [7:0] dr_cnt;
        logic dr_n;
        logic sdo;
        logic oe_n;
    } aol_dev_s;

    localparam logic [7:0] MOD_LAST = 8'(MOD_DIV - 1);
    localparam logic [7:0] DR_LOW = 8'(MOD_DIV / 2);

    aol_dev_s st;
    aol_dev_s next_st;

    assign link.sdo_out = st.sdo;
    assign link.sdo_oe_n = st.oe_n;
    assign link.data_ready_n = st.dr_n;
    assign channel_ready_flags = st.flags;

    // ======================================================================
    // next state
    always_comb
    begin
        logic sck_new;
        logic cs_new;
        logic rise;
        logic fall;
        logic [CH_N-1:0] cap;
        logic [WORD_W-1:0] word;
        logic [15:0] base;
        sck_new = st.sck_f;
        cs_new = st.cs_f;
        rise = 1'b0;
        fall = 1'b0;
        cap = '0;
        word = '0;
        base = '0;
        next_st = st;

        // three-stage synchronisers, second and third must agree
        next_st.sck_s = {st.sck_s[1:0], link.sck};
        next_st.cs_s = {st.cs_s[1:0], link.cs_n};
        next_st.sdi_s = {st.sdi_s[1:0], link.sdi};
        if (st.sck_s[1] == st.sck_s[2])
            sck_new = st.sck_s[1];
        if (st.cs_s[1] == st.cs_s[2])
            cs_new = st.cs_s[1];
        if (st.sdi_s[1] == st.sdi_s[2])
            next_st.sdi_f = st.sdi_s[1];
        next_st.sck_f = sck_new;
        next_st.cs_f = cs_new;
        rise = sck_new & ~st.sck_f;
        fall = ~sck_new & st.sck_f;

        // ==================================================================
        // serial side
        case (st.st)
            DS_IDLE:
            begin
                next_st.oe_n = 1'b1;
                if (!cs_new)
                begin
                    next_st.st = DS_CMD;
                    next_st.cmd_cnt = '0;
                    next_st.crc = '0;
                    next_st.left = '0;
                    next_st.in_crc = 1'b0;
                    next_st.seq_end = 1'b0;
                end
            end
            DS_CMD:
            begin
                next_st.oe_n = 1'b1;
                if (rise)
                begin
                    next_st.cmd = {st.cmd[6:0], st.sdi_f};
                    next_st.cmd_cnt = st.cmd_cnt + 3'd1;
                    if (st.cmd_cnt == 3'(CMD_BITS - 1))
                    begin
                        next_st.ptr = st.cmd[4:0];
                        next_st.is_read = st.sdi_f;
                        next_st.st = DS_DATA;
                    end
                end
            end
            default:
            begin
                // input is not looked at here until chip select rises
                if (fall && st.is_read)
                begin
                    if (st.left > 6'd1)
                    begin
                        next_st.sr = {st.sr[30:0], 1'b0};
                        next_st.sdo = st.sr[30];
                        next_st.left = st.left - 6'd1;
                        if (!st.in_crc)
                            next_st.crc = aol_crc_step(st.crc, st.sr[30]);
                    end
                    else if (st.seq_end && read_checksum_enable)
                    begin
                        next_st.sr = {st.crc, 16'h0000};
                        next_st.sdo = st.crc[15];
                        next_st.left = checksum_width32 ? 6'd32 : 6'd16;
                        next_st.in_crc = 1'b1;
                        next_st.seq_end = 1'b0;
                        next_st.oe_n = 1'b0;
                    end
                    else
                    begin
                        // a new channel word takes the stage-two value here, the status word the flags
                        if (st.ptr <= ADDR_CH2)
                        begin
                            word = st.latch[st.ptr[1:0]];
                            next_st.flags[st.ptr[1:0]] = 1'b1;
                        end
                        else if (st.ptr == ADDR_STATUS)
                            word = {{(WORD_W-CH_N){1'b0}}, st.flags};
                        base = (st.seq_end || st.in_crc) ? 16'h0000 : st.crc;
                        next_st.sr = {word, 8'h00};
                        next_st.sdo = word[WORD_W-1];
                        next_st.left = 6'(WORD_W);
                        next_st.in_crc = 1'b0;
                        next_st.oe_n = 1'b0;
                        next_st.crc = aol_crc_step(base, word[WORD_W-1]);
                        // advance as soon as a word is loaded, before it is shifted out
                        if (st.ptr == ADDR_CH2)
                        begin
                            next_st.ptr = ADDR_CH0;
                            next_st.seq_end = 1'b1;
                        end
                        else if (st.ptr < ADDR_CH2)
                        begin
                            next_st.ptr = st.ptr + 5'd1;
                            next_st.seq_end = 1'b0;
                        end
                        else
                            next_st.seq_end = 1'b1;
                    end
                end
            end
        endcase
        if (cs_new)
        begin
            next_st.st = DS_IDLE;
            next_st.oe_n = 1'b1;
        end

        // ==================================================================
        // modulator clock and stage one
        next_st.mod_cnt = (st.mod_cnt == MOD_LAST) ? 8'h00 : st.mod_cnt + 8'h01;
        for (int i = 0; i < CH_N; i++)
        begin
            if (conv_strobe[i])
                next_st.raw[i] = conv_data[i];
        end
        if (st.mod_cnt == 8'h00)
        begin
            if (link_latch_all)
            begin
                if ((channel_active != '0) &&
                    ((st.pend & channel_active) == channel_active))
                    cap = channel_active;
            end
            else
                cap = st.pend;
        end
        for (int i = 0; i < CH_N; i++)
        begin
            if (cap[i])
            begin
                next_st.latch[i] = st.raw[i];
                next_st.flags[i] = 1'b0;
            end
        end
        next_st.pend = (st.pend & ~cap) | conv_strobe;

        // ready pulse, low for half a modulator period
        if (st.dr_cnt != 8'h00)
        begin
            next_st.dr_cnt = st.dr_cnt - 8'h01;
            if (st.dr_cnt == 8'h01)
                next_st.dr_n = 1'b1;
        end
        if (cap != '0)
        begin
            next_st.dr_cnt = DR_LOW;
            next_st.dr_n = 1'b0;
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            st <= '0;
            st.sck_s <= 3'b000;
            st.cs_s <= 3'b111;
            st.cs_f <= 1'b1;
            st.flags <= 3'b111;
            st.dr_n <= 1'b1;
            st.oe_n <= 1'b1;
        end
        else
            st <= next_st;
    end

endmodule // aol_device
`default_nettype wire

// ---- design/aol_host.sv ----
/*
 * controller end: runs one continuous read sequence on command, checks
 * the appended checksum, raises events.
 * assumes a plain register port on sys_clk and the converter end across
 * the link.
 */
`timescale 1ns/1ps
`default_nettype none
module aol_host
    import aol_pkg::*;
#(
    parameter int unsigned SCK_HALF = 4
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    aol_link_if.host link,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);

    typedef struct packed {
        aol_host_state_e st;
        logic [4:0] addr;
        logic crc_en;
        logic crc32;
        logic wait_dr;
        logic [2:0] mask;
        logic [2:0] ev;
        logic [CH_N-1:0][WORD_W-1:0] data;
        logic [15:0] crc_rx;
        logic [15:0] crc_calc;
        logic [2:0] sdo_s;
        logic [2:0] dr_s;
        logic sdo_f;
        logic dr_f;
        logic sck;
        logic cs_n;
        logic sdi;
        logic [7:0] div;
        logic [5:0] bits;
        logic [31:0] sr;
        logic [4:0] ptr;
        logic [7:0] dly;
        logic [31:0] rdata;
        logic irq;
    } aol_host_s;

    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

    aol_host_s st;
    aol_host_s next_st;

    assign link.sck = st.sck;
    assign link.cs_n = st.cs_n;
    assign link.sdi = st.sdi;
    assign reg_rdata = st.rdata;
    assign irq = st.irq;

    always_comb
    begin
        logic tick;
        logic sample;
        logic dr_new;
        logic sdo_new;
        logic [2:0] set_ev;
        tick = (st.div == 8'h00);
        sample = 1'b0;
        dr_new = st.dr_f;
        sdo_new = st.sdo_f;
        set_ev = '0;
        next_st = st;
        next_st.rdata = '0;

        next_st.sdo_s = {st.sdo_s[1:0], link.sdo};
        next_st.dr_s = {st.dr_s[1:0], link.data_ready_n};
        // take the bit in the cycle the chain settles: one cycle later
        // misses it at the shortest clock half
        if (st.sdo_s[1] == st.sdo_s[2])
            sdo_new = st.sdo_s[1];
        next_st.sdo_f = sdo_new;
        if (st.dr_s[1] == st.dr_s[2])
            dr_new = st.dr_s[1];
        next_st.dr_f = dr_new;
        if (!dr_new && st.dr_f)
            set_ev[EV_DR] = 1'b1;

        // ==================================================================
        // serial clock divider, data taken just before the falling edge
        if (st.st inside {HS_CMD, HS_WORD, HS_CRC, HS_END})
        begin
            next_st.div = tick ? HALF_LAST : st.div - 8'h01;
            if (tick && st.st != HS_END)
            begin
                next_st.sck = ~st.sck;
                sample = st.sck;
            end
        end

        case (st.st)
            HS_IDLE:
            begin
                if (reg_wr && reg_addr == HREG_CTRL && reg_wdata[CTRL_GO])
                    next_st.st = reg_wdata[CTRL_WAIT_DR] ? HS_WAIT_DR : HS_DELAY;
            end
            HS_WAIT_DR:
            begin
                if (set_ev[EV_DR])
                    next_st.st = HS_DELAY;
            end
            HS_DELAY:
            begin
                // reading sooner after the ready edge may catch stale words
                next_st.dly = st.dly + 8'h01;
                if (!st.wait_dr || st.dly >= 8'(UPDATE_DELAY_CYC))
                begin
                    next_st.st = HS_CMD;
                    next_st.cs_n = 1'b0;
                    next_st.sck = 1'b0;
                    next_st.div = HALF_LAST;
                    next_st.sr = {2'b00, st.addr, 1'b1, 24'h00_0000};
                    next_st.sdi = 1'b0;
                    next_st.bits = 6'(CMD_BITS);
                    next_st.ptr = st.addr;
                    next_st.crc_calc = '0;
                end
            end
            HS_CMD:
            begin
                if (sample)
                begin
                    next_st.sr = {st.sr[30:0], 1'b0};
                    next_st.sdi = st.sr[30];
                    next_st.bits = st.bits - 6'd1;
                    if (st.bits == 6'd1)
                    begin
                        next_st.st = HS_WORD;
                        next_st.bits = 6'(WORD_W);
                    end
                end
            end
            HS_WORD:
            begin
                if (sample)
                begin
                    next_st.sr = {st.sr[30:0], sdo_new};
                    next_st.crc_calc = aol_crc_step(st.crc_calc, sdo_new);
                    next_st.bits = st.bits - 6'd1;
                    if (st.bits == 6'd1)
                    begin
                        next_st.bits = 6'(WORD_W);
                        next_st.data[st.ptr[1:0]] = {st.sr[22:0], sdo_new};
                        if (st.ptr < ADDR_CH2)
                            next_st.ptr = st.ptr + 5'd1;
                        else if (st.crc_en)
                        begin
                            next_st.st = HS_CRC;
                            next_st.bits = st.crc32 ? 6'd32 : 6'd16;
                        end
                        else
                            next_st.st = HS_END;
                    end
                end
            end
            HS_CRC:
            begin
                if (sample)
                begin
                    next_st.bits = st.bits - 6'd1;
                    if (st.bits > 6'd16 || !st.crc32)
                        next_st.crc_rx = {st.crc_rx[14:0], sdo_new};
                    if (st.bits == 6'd1)
                        next_st.st = HS_END;
                end
            end
            HS_END:
            begin
                next_st.cs_n = 1'b1;
                if (st.cs_n && tick)
                begin
                    next_st.st = HS_IDLE;
                    set_ev[EV_DONE] = 1'b1;
                    if (st.crc_en && st.crc_rx != st.crc_calc)
                        set_ev[EV_CRC_ERR] = 1'b1;
                end
            end
            default:
                next_st.st = HS_IDLE;
        endcase

        // ==================================================================
        // register port
        if (reg_wr)
        begin
            if (reg_addr == HREG_CTRL && st.st == HS_IDLE)
            begin
                next_st.addr = reg_wdata[CTRL_ADDR_LSB +: 5];
                next_st.crc_en = reg_wdata[CTRL_CRC_EN];
                next_st.crc32 = reg_wdata[CTRL_CRC32];
                next_st.wait_dr = reg_wdata[CTRL_WAIT_DR];
                next_st.dly = '0;
            end
            else if (reg_addr == HREG_MASK)
                next_st.mask = reg_wdata[2:0];
        end
        if (reg_rd)
        begin
            if (reg_addr == HREG_CTRL)
                next_st.rdata = {22'h00_0000, st.st != HS_IDLE, st.wait_dr,
                                 st.crc32, st.crc_en, st.addr, 1'b0};
            else if (reg_addr == HREG_EVENT)
                next_st.rdata = {29'h0000_0000, st.ev};
            else if (reg_addr == HREG_MASK)
                next_st.rdata = {29'h0000_0000, st.mask};
            else if (reg_addr >= HREG_DATA0 && reg_addr <= HREG_DATA2)
                next_st.rdata = {8'h00, st.data[2'(reg_addr - HREG_DATA0)]};
            else if (reg_addr == HREG_CRC)
                next_st.rdata = {16'h0000, st.crc_rx};
        end
        // a new event wins over the clearing read
        next_st.ev = ((reg_rd && reg_addr == HREG_EVENT) ? 3'b000 : st.ev)
                     | set_ev;
        next_st.irq = |(next_st.ev & next_st.mask);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            st <= '0;
            st.cs_n <= 1'b1;
            st.sdo_s <= 3'b111;
            st.dr_s <= 3'b111;
            st.sdo_f <= 1'b1;
            st.dr_f <= 1'b1;
        end
        else
            st <= next_st;
    end

endmodule // aol_host
`default_nettype wire

// ---- verif/aol_link_assertions.sv ----
/*
 * checker for the serial link between converter and controller ends;
 * assumes MOD_DIV of 4 on the converter end and one clock domain
 */
`timescale 1ns/1ps
`default_nettype none
module aol_link_assertions
    import aol_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    input wire logic data_ready_n,
    input wire logic [CH_N-1:0] channel_ready_flags
);
    // ======================================================================
    // sequences
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // low for half a modulator period of four clocks
    sequence dr_low_half;
        !data_ready_n [*2] ##1 data_ready_n;
    endsequence
    sequence cs_idle;
        cs_n [*5];
    endsequence

    // ======================================================================
    // properties
    AST_DR_WIDTH: assert property ($fell(data_ready_n) |-> dr_low_half)
        else $error("ready pulse width wrong");
    AST_DR_GAP: assert property ($rose(data_ready_n) |-> data_ready_n [*2])
        else $error("ready pulses too close");
    AST_OE_CMD: assert property ($fell(cs_n) |-> sdo_oe_n [*8])
        else $error("output driven during control byte");
    AST_OE_RELEASE: assert property (cs_idle |-> sdo_oe_n)
        else $error("output not released after frame");
    // link edges reach the converter four clocks late, so driving may
    // begin just as the clock rises; it must follow a low phase
    AST_DRIVE_START: assert property ($fell(sdo_oe_n)
        |-> !cs_n && !$past(sck))
        else $error("output driven outside a word");
    // the word being shifted holds once the clock has been high for three cycles
    AST_SDO_HOLD: assert property (!sdo_oe_n && sck && $past(sck)
        && $past(sck, 2) |-> $stable(sdo_out))
        else $error("output changed in clock high phase");
    AST_FLAGS_ON_DR: assert property ($fell(data_ready_n)
        |-> channel_ready_flags != 3'b111)
        else $error("no fresh flag with ready pulse");
    AST_FLAG_CAUSE: assert property (|($past(channel_ready_flags)
        & ~channel_ready_flags) |-> $fell(data_ready_n))
        else $error("flag cleared without ready pulse");
endmodule // aol_link_assertions
`default_nettype wire

// ---- verif/tb_adc_output_latch_read_crc.sv ----
/*
 * testbench: converter and controller ends joined by the link;
 * drives conversions and the controller register port
 */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_output_latch_read_crc;
    import aol_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [CH_N-1:0] conv_strobe = '0;
    logic [CH_N-1:0][WORD_W-1:0] conv_data = '0;
    logic [CH_N-1:0] channel_active = 3'b111;
    logic link_latch_all = 1'b1;
    logic read_checksum_enable = 1'b0;
    logic checksum_width32 = 1'b0;
    logic [3:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq;
    logic [CH_N-1:0] flags;
    logic [CH_N-1:0][WORD_W-1:0] words = '0;
    logic exp_irq = 1'b0;
    int fails = 0;
    int n_checks = 0;

    // ======================================================================
    // instances
    aol_link_if link ();
    aol_device #(.MOD_DIV(4)) i_aol_device (.sys_clk(sys_clk),
        .reset_n(reset_n), .link(link), .conv_strobe(conv_strobe),
        .conv_data(conv_data), .channel_active(channel_active),
        .link_latch_all(link_latch_all),
        .read_checksum_enable(read_checksum_enable),
        .checksum_width32(checksum_width32), .channel_ready_flags(flags));
    aol_host #(.SCK_HALF(4)) i_aol_host (.sys_clk(sys_clk),
        .reset_n(reset_n), .link(link), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    aol_link_assertions i_aol_link_assertions (.sys_clk(sys_clk),
        .reset_n(reset_n), .sck(link.sck), .cs_n(link.cs_n),
        .sdo_out(link.sdo_out), .sdo_oe_n(link.sdo_oe_n),
        .data_ready_n(link.data_ready_n), .channel_ready_flags(flags));

    initial
        forever #12.5 sys_clk = ~sys_clk;

    // ======================================================================
    // shared tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // reference checksum over the words a sequence from first sends
    function automatic logic [15:0] crc_ref(input int first);
        logic [15:0] c;
        logic fb;
        c = 16'h0000;
        for (int w = first; w < CH_N; w++)
            for (int b = WORD_W - 1; b >= 0; b--)
            begin
                fb = c[15] ^ words[w][b];
                c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
            end
        return c;
    endfunction

    task automatic conv(input logic [CH_N-1:0] m, input logic [23:0] v,
                        input logic [CH_N-1:0] exp_flags);
        int i;
        @(posedge sys_clk);
        conv_strobe <= m;
        for (i = 0; i < CH_N; i++)
        begin
            conv_data[i] <= v + 24'(i);
            if (m[i])
                words[i] = v + 24'(i);
        end
        @(posedge sys_clk);
        conv_strobe <= '0;
        for (i = 0; i < 50 && link.data_ready_n !== 1'b0; i++)
            @(posedge sys_clk);
        if (i == 50)
        begin
            fails++;
            final_report();
        end
        #1 chk(32'(flags), 32'(exp_flags), "ready flags");
    endtask

    task automatic run_seq(input int first, input logic ce, input logic c32,
                           input logic wdr);
        logic [31:0] d;
        int i;
        @(posedge sys_clk);
        read_checksum_enable <= ce;
        checksum_width32 <= c32;
        wr(HREG_CTRL, 32'h0000_0001 | (32'(first) << CTRL_ADDR_LSB)
            | (32'(ce) << CTRL_CRC_EN) | (32'(c32) << CTRL_CRC32)
            | (32'(wdr) << CTRL_WAIT_DR));
        // a late conversion catches a host that would not wait for ready
        repeat (wdr ? 100 : 4) @(posedge sys_clk);
        if (wdr)
            conv(3'b001, 24'h33_0000, 3'b110);
        d = 32'h0000_0200;
        for (i = 0; i < 2000 && d[CTRL_BUSY] !== 1'b0; i++)
            rd(HREG_CTRL, d);
        if (i == 2000)
        begin
            fails++;
            final_report();
        end
        chk(32'(irq), 32'(exp_irq), "irq level");
        rd(HREG_EVENT, d);
        chk(d & 32'h0000_0003, 32'h0000_0001, "done event");
        chk(32'(irq), 32'h0000_0000, "irq after event read");
        for (i = first; i < CH_N; i++)
        begin
            rd(HREG_DATA0 + 4'(i), d);
            chk(d, 32'(words[i]), "channel word");
        end
        if (ce)
        begin
            rd(HREG_CRC, d);
            chk(d & 32'h0000_FFFF, 32'(crc_ref(first)), "checksum");
        end
        chk(32'(flags), 32'h0000_0007, "flags after read");
    endtask

    // ======================================================================
    // scenarios
    task automatic t_reset();
        logic [31:0] d;
        chk(32'(flags), 32'h0000_0007, "reset flags");
        chk(32'(link.sdo_oe_n), 32'h0000_0001, "reset release");
        rd(4'hF, d);
        chk(d, 32'h0000_0000, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_linked();
        @(posedge sys_clk);
        channel_active <= 3'b011;
        conv(3'b011, 24'h12_3456, 3'b100);
        run_seq(0, 1'b1, 1'b0, 1'b0);
        $display("test linked read done");
    endtask

    task automatic t_unlinked();
        @(posedge sys_clk);
        link_latch_all <= 1'b0;
        conv(3'b010, 24'hA5_0F00, 3'b101);
        run_seq(1, 1'b1, 1'b1, 1'b0);
        $display("test unlinked read done");
    endtask

    task automatic t_plain_irq();
        wr(HREG_MASK, 32'h0000_0001);
        exp_irq = 1'b1;
        conv(3'b100, 24'h00_FFFF, 3'b011);
        run_seq(2, 1'b0, 1'b0, 1'b0);
        run_seq(0, 1'b0, 1'b0, 1'b1);
        $display("test plain read done");
    endtask

    initial
    begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_linked();
        t_unlinked();
        t_plain_irq();
        final_report();
    end
endmodule // tb_adc_output_latch_read_crc
`default_nettype wire
